// ### bench/core_model.sv
// Core model that issues clear-watchdog and halt instructions.
`timescale 1ns/1ps
module core_model (
	input wire logic ref_clk_i,
	input wire logic cpu_reset_i,
	input wire logic [8:0] gap_i,
	input wire logic halt_req_i,
	output logic clear_watchdog_instruction_o = 1'b0,
	output logic halt_o = 1'b0
);
	logic [8:0] cnt_r = 9'h000;
	// A core held in reset fetches nothing, so it issues no instruction then.
	always @(posedge ref_clk_i)
	begin
		cnt_r <= (cnt_r >= gap_i) ? 9'h000 : cnt_r + 9'h001;
		clear_watchdog_instruction_o <= !cpu_reset_i && gap_i != 9'h000 && cnt_r == gap_i;
		halt_o <= !cpu_reset_i && halt_req_i;
	end
endmodule // core_model

// ### bench/test_watchdog_reset_control.sv
// Self-checking bench of the watchdog and reset controller.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin check_count++; if ((e) !== (s)) begin n_mismatch++; \
	$display("FAIL %s exp %0h got %0h", nm, e, s); end end
module test_watchdog_reset_control;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic reset_pin_n_i = 1'b1;
	logic lv_detect_i = 1'b0;
	logic low_speed_rc_osc_clk_i = 1'b0;
	logic halt_req = 1'b0;
	logic [8:0] gap = 9'h000;
	logic clear_watchdog_instruction_i, halt_i, cpu_reset_o, sleep_o, wake_o, pc_sp_clear_o;
	logic timeout_flag_o, powerdown_flag_o;
	logic [7:0] rdata_o, port_data_o, port_dir_o;
	int n_mismatch = 0;
	int check_count = 0;
	int n_rst = 0;
	always #2.5 ref_clk_i = ~ref_clk_i;
	// The slow oscillator runs far faster than in silicon to keep the run short.
	always #20 low_speed_rc_osc_clk_i = ~low_speed_rc_osc_clk_i;
	always @(negedge ref_clk_i) n_rst += int'(cpu_reset_o === 1'b1);
	watchdog_reset_control #(.RESET_DELAY_CYCLES(20)) i_dut (.ref_clk_i, .rst_i, .addr_i, .wdata_i,
		.wr_i, .rd_i, .rdata_o, .clear_watchdog_instruction_i, .halt_i, .reset_pin_n_i, .lv_detect_i, .low_speed_rc_osc_clk_i,
		.cpu_reset_o, .sleep_o, .wake_o, .pc_sp_clear_o, .timeout_flag_o, .powerdown_flag_o,
		.port_data_o, .port_dir_o);
	core_model i_core (.ref_clk_i, .cpu_reset_i(cpu_reset_o), .gap_i(gap), .halt_req_i(halt_req),
		.clear_watchdog_instruction_o(clear_watchdog_instruction_i), .halt_o(halt_i));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		`CHK("rdata", e, rdata_o)
	endtask
	// Event 0 is reset entry, 1 is reset exit, 2 is a sleep timeout pulse.
	task automatic wait_ev(input int k, input int lim, output int n);
		n = 0;
		while (!((k == 0 && cpu_reset_o === 1'b1) || (k == 1 && cpu_reset_o === 1'b0)
			|| (k == 2 && pc_sp_clear_o === 1'b1)))
		begin
			@(negedge ref_clk_i);
			n++;
			if (n > lim)
			begin
				n_mismatch++;
				report_and_stop();
			end
		end
	endtask
	task automatic do_halt();
		halt_req <= 1'b1;
		@(posedge ref_clk_i);
		halt_req <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
	endtask
	initial
	begin
		int n;
		logic [7:0] pd;
		void'($urandom(32'h16E2));
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		wait_ev(1, 40, n);
		`CHK("delay", 1'b1, n >= 18 && n <= 23)
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h07);
		rd(8'h02, 8'h00);
		rd(8'h04, 8'hFF);
		rd(8'h05, 8'hFF);
		rd(8'h09, 8'h00);
		rd(8'h03, 8'h00);
		pd = 8'($urandom);
		wr(8'h04, pd);
		wr(8'h05, ~pd);
		@(negedge ref_clk_i);
		`CHK("port", {pd, ~pd}, {port_data_o, port_dir_o})
		for (int ts = 0; ts < 2; ts++)
		begin
			wr(8'h00, 8'h80);
			wr(8'h01, 8'(ts));
			gap <= 9'(40 + $urandom % 200);
			n = n_rst;
			repeat (1500) @(posedge ref_clk_i);
			`CHK("cleared", n, n_rst)
			gap <= 9'h000;
			wait_ev(0, 600, n);
			`CHK("timeout", 1'b1, n + 245 >= (256 << ts) && n <= (256 << ts) + 6)
			`CHK("to flag", 1'b1, timeout_flag_o)
			wait_ev(1, 40, n);
			`CHK("port rst", 16'hFFFF, {port_data_o, port_dir_o})
			rd(8'h03, 8'h01);
		end
		// A short timeout makes the disabled check able to fail if counting went on.
		wr(8'h01, 8'h00);
		wr(8'h00, 8'hAD);
		n = n_rst;
		repeat (700) @(posedge ref_clk_i);
		`CHK("disabled", n, n_rst)
		gap <= 9'h020;
		repeat (100) @(posedge ref_clk_i);
		gap <= 9'h000;
		rd(8'h03, 8'h01);
		wr(8'h00, 8'h00);
		pd = 8'($urandom);
		wr(8'h04, pd);
		do_halt();
		wait_ev(2, 2400, n);
		`CHK("wake", 3'h4, {wake_o, cpu_reset_o, sleep_o})
		`CHK("flags", 2'h3, {timeout_flag_o, powerdown_flag_o})
		`CHK("kept", pd, port_data_o)
		rd(8'h01, 8'h00);
		wr(8'h00, 8'h80);
		do_halt();
		lv_detect_i <= 1'b1;
		repeat (700) @(posedge ref_clk_i);
		`CHK("asleep", 2'h2, {sleep_o, cpu_reset_o})
		lv_detect_i <= 1'b0;
		rst_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		wait_ev(1, 40, n);
		`CHK("por flags", 2'h0, {timeout_flag_o, powerdown_flag_o})
		for (int k = 0; k < 2; k++)
		begin
			wr(k ? 8'h02 : 8'h00, k ? 8'hE3 : 8'h03);
			if (k)
				rd(8'h02, 8'h03);
			wait_ev(0, 60, n);
			`CHK("code", 1'b1, n >= 8 && n <= 32)
			wait_ev(1, 40, n);
		end
		@(posedge ref_clk_i);
		n = n_rst;
		lv_detect_i <= 1'b1;
		reset_pin_n_i <= 1'b0;
		repeat (150) @(posedge ref_clk_i);
		lv_detect_i <= 1'b0;
		reset_pin_n_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		`CHK("lv short", n, n_rst)
		lv_detect_i <= 1'b1;
		wait_ev(0, 230, n);
		@(posedge ref_clk_i);
		lv_detect_i <= 1'b0;
		`CHK("lv", 1'b1, n >= 195)
		wait_ev(1, 40, n);
		wr(8'h02, 8'h15);
		reset_pin_n_i <= 1'b0;
		wait_ev(0, 10, n);
		@(posedge ref_clk_i);
		reset_pin_n_i <= 1'b1;
		wait_ev(1, 40, n);
		rd(8'h02, 8'h00);
		report_and_stop();
	end
endmodule // test_watchdog_reset_control

// ### bench/watchdog_reset_control_assertions.sv
// Port assertions of the watchdog and reset controller.
`timescale 1ns/1ps
module watchdog_reset_control_assertions (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic halt_i,
	input wire logic cpu_reset_o,
	input wire logic sleep_o,
	input wire logic wake_o,
	input wire logic pc_sp_clear_o,
	input wire logic timeout_flag_o,
	input wire logic powerdown_flag_o,
	input wire logic [7:0] port_data_o,
	input wire logic [7:0] port_dir_o
);
	default clocking @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	a_por_state: assert property (disable iff (1'b0) rst_i |=> cpu_reset_o
		&& !timeout_flag_o && !powerdown_flag_o && port_data_o == 8'hFF && port_dir_o == 8'hFF)
		else $error("power-on state wrong");
	a_reset_hold: assert property ($fell(rst_i) |-> cpu_reset_o [*8])
		else $error("reset delay too short");
	a_halt_sleep: assert property (halt_i && !cpu_reset_o && !sleep_o |=> sleep_o
		&& powerdown_flag_o && !timeout_flag_o)
		else $error("halt did not enter sleep");
	a_pcsp_wake: assert property (pc_sp_clear_o |-> wake_o && timeout_flag_o
		&& powerdown_flag_o && !cpu_reset_o)
		else $error("sleep timeout outputs wrong");
	a_pcsp_sleep: assert property (pc_sp_clear_o |-> $past(sleep_o) && !sleep_o)
		else $error("pc clear outside sleep");
	a_wake_pulse: assert property (wake_o |=> !wake_o)
		else $error("wake longer than one cycle");
	a_pinsel_read: assert property (rd_i && addr_i == 8'h02 |=> rdata_o[7:5] == 3'h0)
		else $error("pin select high bits set");
	a_to_cause: assert property ($rose(timeout_flag_o) |-> cpu_reset_o || pc_sp_clear_o)
		else $error("timeout flag without timeout");
endmodule // watchdog_reset_control_assertions
bind watchdog_reset_control watchdog_reset_control_assertions i_chk (.ref_clk_i, .rst_i, .addr_i,
	.rd_i, .rdata_o, .halt_i, .cpu_reset_o, .sleep_o, .wake_o, .pc_sp_clear_o, .timeout_flag_o,
	.powerdown_flag_o, .port_data_o, .port_dir_o);

// ### verilog/watchdog_reset_control.sv
// Watchdog timer with power-on, reset-pin, low-voltage and key-error reset control.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "watchdog_reset_control_cfg.svh"

module watchdog_reset_control #(
	parameter int RESET_DELAY_CYCLES = `WDR_RST_DELAY_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic clear_watchdog_instruction_i,
	input wire logic halt_i,
	input wire logic reset_pin_n_i,
	input wire logic lv_detect_i,
	input wire logic low_speed_rc_osc_clk_i,
	output logic cpu_reset_o,
	output logic sleep_o,
	output logic wake_o,
	output logic pc_sp_clear_o,
	output logic timeout_flag_o,
	output logic powerdown_flag_o,
	output logic [7:0] port_data_o,
	output logic [7:0] port_dir_o
);

	localparam logic [23:0] DLY_LAST = 24'(RESET_DELAY_CYCLES - 1);
	localparam logic [15:0] LVR_MIN = 16'(`WDR_LVR_MIN_CYC);

	watchdog_reset_control_pkg::wdr_state_s s, n;

	logic low_speed_rc_osc_tick;
	logic src_tick;
	logic enabled;
	logic pin_low;
	logic lv_hold;
	logic full_rst;
	logic wdt_to;
	logic sw_clear;

	function automatic logic wdt_expired(input logic [15:0] c, input logic [2:0] w);
		// A shorter timeout chosen while counting must still fire, so compare with >=.
		wdt_expired = (c >= ((16'h0100 << w) - 16'h0001));
	endfunction

	function automatic logic key_valid(input logic [5:0] k);
		key_valid = (k == `WDR_KEY_EN) || (k == `WDR_KEY_DIS);
	endfunction

	function automatic logic pin_code_valid(input logic [4:0] p);
		pin_code_valid = (p == `WDR_PIN_PORT) || (p == `WDR_PIN_RES);
	endfunction

	always_comb
	begin
		n = s;
		n.wake = 1'b0;
		n.pcsp = 1'b0;
		n.rdata = 8'h00;
		n.sync_pin = {s.sync_pin[0], reset_pin_n_i};
		n.sync_lv = {s.sync_lv[0], lv_detect_i};
		n.sync_low_speed_rc_osc = {s.sync_low_speed_rc_osc[1:0], low_speed_rc_osc_clk_i};
		low_speed_rc_osc_tick = s.sync_low_speed_rc_osc[1] & ~s.sync_low_speed_rc_osc[2];
		enabled = (s.enable_key == `WDR_KEY_EN);
		full_rst = 1'b0;
		wdt_to = 1'b0;
		sw_clear = 1'b0;

		// The system clock and its divider stop in sleep; only the slow oscillator runs.
		if (s.st != watchdog_reset_control_pkg::ST_SLEEP)
		begin
			n.div4 = s.div4 + 2'h1;
		end
		case (s.clock_select)
			`WDR_CSEL_LOW_SPEED_RC_OSC: src_tick = low_speed_rc_osc_tick;
			`WDR_CSEL_DIV4: src_tick = (s.div4 == 2'h3) && (s.st != watchdog_reset_control_pkg::ST_SLEEP);
			default: src_tick = (s.st != watchdog_reset_control_pkg::ST_SLEEP);
		endcase

		// A pin in port mode never resets, whatever level it carries.
		pin_low = ~s.sync_pin[1] && (s.pin_select_code == `WDR_PIN_RES);

		// The filter is held clear in sleep so a dip there cannot fire on wake-up.
		if (s.st == watchdog_reset_control_pkg::ST_SLEEP || !s.sync_lv[1])
		begin
			n.low_voltage_reset = 16'h0000;
		end
		else if (s.low_voltage_reset != LVR_MIN)
		begin
			n.low_voltage_reset = s.low_voltage_reset + 16'h0001;
		end
		lv_hold = s.sync_lv[1] && (s.low_voltage_reset == LVR_MIN)
			&& (s.st != watchdog_reset_control_pkg::ST_SLEEP);

		if (s.pend != 2'h0 && low_speed_rc_osc_tick)
		begin
			if (s.pend == `WDR_PEND_LAST)
			begin
				full_rst = 1'b1;
			end
			else
			begin
				n.pend = s.pend + 2'h1;
			end
		end

		unique case (s.st)
			watchdog_reset_control_pkg::ST_HOLD:
			begin
				n.cnt = 16'h0000;
				n.div4 = 2'h0;
				if (pin_low || lv_hold)
				begin
					n.dly = 24'h000000;
				end
				else if (s.dly >= DLY_LAST)
				begin
					n.dly = 24'h000000;
					n.st = watchdog_reset_control_pkg::ST_RUN;
				end
				else
				begin
					n.dly = s.dly + 24'h000001;
				end
			end
			watchdog_reset_control_pkg::ST_RUN:
			begin
				if (halt_i)
				begin
					sw_clear = 1'b1;
					n.st = watchdog_reset_control_pkg::ST_SLEEP;
					n.powerdown_flag = 1'b1;
					n.timeout_flag = 1'b0;
				end
				else if (clear_watchdog_instruction_i && enabled)
				begin
					sw_clear = 1'b1;
					n.powerdown_flag = 1'b0;
					n.timeout_flag = 1'b0;
				end
				else if (enabled && src_tick)
				begin
					if (wdt_expired(s.cnt, s.timeout_select))
					begin
						wdt_to = 1'b1;
					end
					else
					begin
						n.cnt = s.cnt + 16'h0001;
					end
				end
			end
			watchdog_reset_control_pkg::ST_SLEEP:
			begin
				if (enabled && src_tick)
				begin
					if (wdt_expired(s.cnt, s.timeout_select))
					begin
						wdt_to = 1'b1;
					end
					else
					begin
						n.cnt = s.cnt + 16'h0001;
					end
				end
			end
			default:
			begin
				full_rst = 1'b1;
			end
		endcase

		if (sw_clear)
		begin
			n.cnt = 16'h0000;
			n.div4 = 2'h0;
		end

		if (rd_i)
		begin
			case (addr_i)
				`WDR_ADDR_CTRL: n.rdata = {s.clock_select, s.enable_key};
				`WDR_ADDR_TMO: n.rdata = {5'h00, s.timeout_select};
				`WDR_ADDR_PINSEL: n.rdata = {3'h0, s.pin_select_code};
				`WDR_ADDR_STATUS: n.rdata = {4'h0, s.slp, s.cpu_rst, s.powerdown_flag,
					s.timeout_flag};
				`WDR_ADDR_PDATA: n.rdata = s.port_data;
				`WDR_ADDR_PDIR: n.rdata = s.port_dir;
				default: n.rdata = 8'h00;
			endcase
		end

		if (wr_i)
		begin
			case (addr_i)
				`WDR_ADDR_CTRL:
				begin
					n.clock_select = wdata_i[7:6];
					n.enable_key = wdata_i[5:0];
					if (!key_valid(wdata_i[5:0]))
					begin
						n.cnt = 16'h0000;
						n.div4 = 2'h0;
						n.pend = 2'h1;
					end
				end
				`WDR_ADDR_TMO: n.timeout_select = wdata_i[2:0];
				`WDR_ADDR_PINSEL:
				begin
					n.pin_select_code = wdata_i[4:0];
					if (!pin_code_valid(wdata_i[4:0]))
					begin
						n.pend = 2'h1;
					end
				end
				`WDR_ADDR_PDATA: n.port_data = wdata_i;
				`WDR_ADDR_PDIR: n.port_dir = wdata_i;
				default:
				begin
				end
			endcase
		end

		if (pin_low || lv_hold)
		begin
			full_rst = 1'b1;
		end

		// A sleep timeout is a warm restart: configuration, ports and the powerdown flag stay.
		if (wdt_to && s.st == watchdog_reset_control_pkg::ST_SLEEP && !full_rst)
		begin
			n.wake = 1'b1;
			n.pcsp = 1'b1;
			n.timeout_flag = 1'b1;
			n.st = watchdog_reset_control_pkg::ST_RUN;
			n.cnt = 16'h0000;
			n.div4 = 2'h0;
		end

		if (full_rst || (wdt_to && s.st == watchdog_reset_control_pkg::ST_RUN))
		begin
			if (wdt_to && !full_rst)
			begin
				n.timeout_flag = 1'b1;
			end
			else
			begin
				n.timeout_flag = s.timeout_flag;
				n.powerdown_flag = s.powerdown_flag;
			end
			n.wake = (s.st == watchdog_reset_control_pkg::ST_SLEEP);
			n.st = watchdog_reset_control_pkg::ST_HOLD;
			n.dly = 24'h000000;
			n.cnt = 16'h0000;
			n.div4 = 2'h0;
			n.pend = 2'h0;
			{n.clock_select, n.enable_key} = `WDR_CTRL_RST;
			n.timeout_select = `WDR_TMO_RST;
			n.pin_select_code = `WDR_PINSEL_RST;
			n.port_data = `WDR_PORT_RST;
			n.port_dir = `WDR_PORT_RST;
		end

		n.cpu_rst = (n.st == watchdog_reset_control_pkg::ST_HOLD);
		n.slp = (n.st == watchdog_reset_control_pkg::ST_SLEEP);
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			s <= '0;
			s.st <= watchdog_reset_control_pkg::ST_HOLD;
			s.cpu_rst <= 1'b1;
			{s.clock_select, s.enable_key} <= `WDR_CTRL_RST;
			s.timeout_select <= `WDR_TMO_RST;
			s.pin_select_code <= `WDR_PINSEL_RST;
			s.timeout_flag <= 1'b0;
			s.powerdown_flag <= 1'b0;
			s.port_data <= `WDR_PORT_RST;
			s.port_dir <= `WDR_PORT_RST;
			s.sync_pin <= 2'h3;
		end
		else
		begin
			s <= n;
		end
	end

	assign rdata_o = s.rdata;
	assign cpu_reset_o = s.cpu_rst;
	assign sleep_o = s.slp;
	assign wake_o = s.wake;
	assign pc_sp_clear_o = s.pcsp;
	assign timeout_flag_o = s.timeout_flag;
	assign powerdown_flag_o = s.powerdown_flag;
	assign port_data_o = s.port_data;
	assign port_dir_o = s.port_dir;

endmodule // watchdog_reset_control

// ### verilog/watchdog_reset_control_cfg.svh
// Offsets, codes, reset values and timing counts of the watchdog and reset controller.
`ifndef WATCHDOG_RESET_CONTROL_CFG_SVH
`define WATCHDOG_RESET_CONTROL_CFG_SVH

`define WDR_ADDR_CTRL 8'h00
`define WDR_ADDR_TMO 8'h01
`define WDR_ADDR_PINSEL 8'h02
`define WDR_ADDR_STATUS 8'h03
`define WDR_ADDR_PDATA 8'h04
`define WDR_ADDR_PDIR 8'h05

`define WDR_KEY_EN 6'h00
`define WDR_KEY_DIS 6'h2D
`define WDR_PIN_PORT 5'h00
`define WDR_PIN_RES 5'h15
`define WDR_CSEL_LOW_SPEED_RC_OSC 2'h0
`define WDR_CSEL_DIV4 2'h1

`define WDR_CTRL_RST 8'h00
`define WDR_TMO_RST 3'h7
`define WDR_PINSEL_RST 5'h00
`define WDR_PORT_RST 8'hFF

`define WDR_PEND_LAST 2'h3
`define WDR_CLK_MHZ 200
`define WDR_RST_DELAY_MS 50
`define WDR_RST_DELAY_CYC (`WDR_RST_DELAY_MS * `WDR_CLK_MHZ * 1000)
`define WDR_LVR_MIN_NS 1000
`define WDR_LVR_MIN_CYC ((`WDR_LVR_MIN_NS * `WDR_CLK_MHZ + 999) / 1000)

`endif

// ### verilog/watchdog_reset_control_pkg.sv
// Types of the watchdog and reset controller.
package watchdog_reset_control_pkg;

	typedef enum logic [1:0] {
		ST_HOLD = 2'h0,
		ST_RUN = 2'h1,
		ST_SLEEP = 2'h2
	} run_state_e;

	typedef struct packed {
		run_state_e st;
		logic [1:0] clock_select;
		logic [5:0] enable_key;
		logic [2:0] timeout_select;
		logic [4:0] pin_select_code;
		logic timeout_flag;
		logic powerdown_flag;
		logic [15:0] cnt;
		logic [1:0] div4;
		logic [23:0] dly;
		logic [1:0] pend;
		logic [15:0] low_voltage_reset;
		logic [7:0] port_data;
		logic [7:0] port_dir;
		logic [7:0] rdata;
		logic cpu_rst;
		logic slp;
		logic wake;
		logic pcsp;
		logic [1:0] sync_pin;
		logic [1:0] sync_lv;
		logic [2:0] sync_low_speed_rc_osc;
	} wdr_state_s;

endpackage
